// >>> src/swt_top.sv
// System watchdog timer with boot monitor, register port and reset-switch debouncer.
// Summary of operation
// - Optional boot monitoring counts from power-up with a 30, 60 or 90 s timeout.
// - Any read of address 201h reloads the full countdown, whatever the data.
// - On expiry the response is chosen by the static action jumper: system reset or NMI.
// - Writing 00 to the control register stops the watchdog and 01 starts it.
// - The run-time period is an 8-bit count of whole seconds, 00-FFh covering 1-255 s.
// - The active-low manual reset switch is debounced and then resets the system.
`timescale 1ns/1ns
`default_nettype none
module swt_top
    import swt_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = swt_pkg::TICK_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES_P = swt_pkg::DEBOUNCE_CYCLES
)
(
    // Clock, reset and clock enable.
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Register port.
    input wire logic [swt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [swt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [swt_pkg::DATA_W-1:0] reg_rdata,
    // Board straps and switch.
    input wire logic [1:0] boot_timeout_sel,
    input wire logic timeout_action_jumper,
    input wire logic manual_reset_switch_n,
    // Responses.
    output logic sys_reset_req,
    output logic wdt_nmi,
    output logic irq
);
    import swt_pkg::*;

    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES_P - 1);
    localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES_P - 1);
    localparam logic [4:0] PULSE_LAST = 5'(RESET_PULSE_CYCLES - 1);

    // Period encoding 00h is taken as the shortest period of one second.
    function automatic logic [7:0] period_secs(input logic [7:0] code);
        period_secs = (code == 8'h00) ? 8'h01 : code;
    endfunction

    function automatic logic [7:0] boot_secs(input logic [1:0] sel);
        case (sel)
            BOOT_30: boot_secs = BOOT_30_S;
            BOOT_60: boot_secs = BOOT_60_S;
            BOOT_90: boot_secs = BOOT_90_S;
            default: boot_secs = 8'h01;
        endcase
    endfunction

    localparam logic [7:0] RELOAD_RST = period_secs(PERIOD_RST);

    // Timer state.
    swt_state_t state_q, state_d;
    logic strap_done_q, strap_done_d;
    logic boot_mode_q, boot_mode_d;
    logic expired_q, expired_d;
    logic [7:0] period_q, period_d;
    logic [7:0] reload_q, reload_d;
    logic [7:0] remain_q, remain_d;
    logic [CNT_W-1:0] presc_q, presc_d;
    // Register and interrupt state.
    logic [EVT_W-1:0] status_q, status_d;
    logic [EVT_W-1:0] int_en_q, int_en_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    // Response and debouncer state.
    logic rst_out_q, rst_out_d;
    logic nmi_q, nmi_d;
    logic [4:0] pulse_q, pulse_d;
    logic sw_level_q, sw_level_d;
    logic [CNT_W-1:0] deb_q, deb_d;

    logic wr_ctrl, rd_retrig, expire, sw_press;
    logic [EVT_W-1:0] evt;

    always_comb
    begin
        wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
        rd_retrig = reg_rd && (reg_addr == OFS_RETRIGGER);
        expire = 1'b0;
        state_d = state_q;
        strap_done_d = 1'b1;
        boot_mode_d = boot_mode_q;
        expired_d = expired_q;
        period_d = period_q;
        reload_d = reload_q;
        remain_d = remain_q;
        presc_d = presc_q;

        if (reg_wr && reg_addr == OFS_PERIOD)
        begin
            period_d = reg_wdata;
        end

        case (state_q)
            SWT_IDLE:
            begin
                remain_d = reload_q;
                presc_d = '0;
                if (!strap_done_q && boot_timeout_sel != BOOT_OFF)
                begin
                    reload_d = boot_secs(boot_timeout_sel);
                    remain_d = boot_secs(boot_timeout_sel);
                    boot_mode_d = 1'b1;
                    state_d = SWT_RUN;
                end
                else if (wr_ctrl && reg_wdata == CTRL_ENABLE)
                begin
                    reload_d = period_secs(period_d);
                    remain_d = period_secs(period_d);
                    boot_mode_d = 1'b0;
                    expired_d = 1'b0;
                    state_d = SWT_RUN;
                end
            end
            SWT_RUN:
            begin
                if (wr_ctrl && reg_wdata == CTRL_DISABLE)
                begin
                    boot_mode_d = 1'b0;
                    state_d = SWT_IDLE;
                end
                else if (wr_ctrl && reg_wdata == CTRL_ENABLE)
                begin
                    reload_d = period_secs(period_d);
                    remain_d = period_secs(period_d);
                    presc_d = '0;
                    boot_mode_d = 1'b0;
                end
                else if (rd_retrig)
                begin
                    remain_d = reload_q;
                    presc_d = '0;
                end
                else if (presc_q == TICK_LAST)
                begin
                    presc_d = '0;
                    if (remain_q <= 8'h01)
                    begin
                        remain_d = 8'h00;
                        state_d = SWT_FIRE;
                    end
                    else
                    begin
                        remain_d = remain_q - 8'h01;
                    end
                end
                else
                begin
                    presc_d = presc_q + CNT_W'(1);
                end
            end
            SWT_FIRE:
            begin
                expire = 1'b1;
                expired_d = 1'b1;
                boot_mode_d = 1'b0;
                state_d = SWT_IDLE;
            end
            default:
            begin
                state_d = SWT_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= SWT_IDLE;
            strap_done_q <= 1'b0;
            boot_mode_q <= 1'b0;
            expired_q <= 1'b0;
            period_q <= PERIOD_RST;
            reload_q <= RELOAD_RST;
            remain_q <= RELOAD_RST;
            presc_q <= '0;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            strap_done_q <= strap_done_d;
            boot_mode_q <= boot_mode_d;
            expired_q <= expired_d;
            period_q <= period_d;
            reload_q <= reload_d;
            remain_q <= remain_d;
            presc_q <= presc_d;
        end
    end

    // Switch debouncer, response pulse, status and read data.
    always_comb
    begin
        sw_press = 1'b0;
        sw_level_d = sw_level_q;
        deb_d = '0;
        if (manual_reset_switch_n != sw_level_q)
        begin
            deb_d = deb_q + CNT_W'(1);
            if (deb_q == DEB_LAST)
            begin
                deb_d = '0;
                sw_level_d = manual_reset_switch_n;
                sw_press = !manual_reset_switch_n;
            end
        end

        rst_out_d = rst_out_q;
        nmi_d = 1'b0;
        pulse_d = pulse_q;
        if (sw_press || (expire && timeout_action_jumper == ACTION_RESET))
        begin
            rst_out_d = 1'b1;
            pulse_d = PULSE_LAST;
        end
        else if (rst_out_q)
        begin
            if (pulse_q == 5'h00)
            begin
                rst_out_d = 1'b0;
            end
            else
            begin
                pulse_d = pulse_q - 5'h01;
            end
        end
        if (expire && timeout_action_jumper == ACTION_NMI)
        begin
            nmi_d = 1'b1;
        end

        evt = '0;
        evt[EVT_TIMEOUT_BIT] = expire;
        evt[EVT_MANUAL_BIT] = sw_press;
        int_en_d = int_en_q;
        status_d = status_q;
        if (reg_wr && reg_addr == OFS_INT_EN)
        begin
            int_en_d = reg_wdata[EVT_W-1:0];
        end
        if (reg_wr && reg_addr == OFS_INT_CLR)
        begin
            status_d = status_q & ~reg_wdata[EVT_W-1:0];
        end
        status_d = status_d | evt;
        irq_d = |(status_d & int_en_d);

        rdata_d = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_CTRL:
                begin
                    rdata_d[CTRL_EN_BIT] = (state_q != SWT_IDLE);
                    rdata_d[CTRL_BOOT_BIT] = boot_mode_q;
                    rdata_d[CTRL_EXPIRED_BIT] = expired_q;
                end
                OFS_PERIOD: rdata_d = period_q;
                OFS_REMAIN: rdata_d = remain_q;
                OFS_STATUS: rdata_d[EVT_W-1:0] = status_q;
                OFS_INT_EN: rdata_d[EVT_W-1:0] = int_en_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sw_level_q <= 1'b1;
            deb_q <= '0;
            rst_out_q <= 1'b0;
            nmi_q <= 1'b0;
            pulse_q <= 5'h00;
            status_q <= '0;
            int_en_q <= INT_EN_RST;
            irq_q <= 1'b0;
            rdata_q <= '0;
        end
        else if (clk_en)
        begin
            sw_level_q <= sw_level_d;
            deb_q <= deb_d;
            rst_out_q <= rst_out_d;
            nmi_q <= nmi_d;
            pulse_q <= pulse_d;
            status_q <= status_d;
            int_en_q <= int_en_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign sys_reset_req = rst_out_q;
    assign wdt_nmi = nmi_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// >>> src/swt_pkg.sv
// Package of constants and types for the system watchdog timer.
`default_nettype none
package swt_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // Register offsets on the plain register port.
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_PERIOD = 12'h004;
    localparam logic [11:0] OFS_REMAIN = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_INT_EN = 12'h010;
    localparam logic [11:0] OFS_INT_CLR = 12'h014;
    localparam logic [11:0] OFS_RETRIGGER = 12'h201;

    // Control values and field positions.
    localparam logic [7:0] CTRL_DISABLE = 8'h00;
    localparam logic [7:0] CTRL_ENABLE = 8'h01;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_BOOT_BIT = 1;
    localparam int unsigned CTRL_EXPIRED_BIT = 2;
    localparam int unsigned EVT_TIMEOUT_BIT = 0;
    localparam int unsigned EVT_MANUAL_BIT = 1;
    localparam int unsigned EVT_W = 2;

    // Reset values.
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [EVT_W-1:0] INT_EN_RST = 2'h0;

    // Boot monitoring selections and their timeouts in seconds.
    localparam logic [1:0] BOOT_OFF = 2'h0;
    localparam logic [1:0] BOOT_30 = 2'h1;
    localparam logic [1:0] BOOT_60 = 2'h2;
    localparam logic [1:0] BOOT_90 = 2'h3;
    localparam logic [7:0] BOOT_30_S = 8'h1E;
    localparam logic [7:0] BOOT_60_S = 8'h3C;
    localparam logic [7:0] BOOT_90_S = 8'h5A;

    // Timing.
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TIME_BASE_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TIME_BASE_S;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int unsigned RESET_PULSE_CYCLES = 16;
    localparam int unsigned CNT_W = 25;

    // Expiry responses selected by the board jumper.
    localparam logic ACTION_NMI = 1'b0;
    localparam logic ACTION_RESET = 1'b1;

    typedef enum logic [1:0] {
        SWT_IDLE,
        SWT_RUN,
        SWT_FIRE
    } swt_state_t;
endpackage
`default_nettype wire

// >>> tb/swt_top_sva.sv
// Port-level property checker for the system watchdog timer.
`timescale 1ns/1ns
`default_nettype none
module swt_sva
    import swt_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = 8,
    parameter int unsigned DEBOUNCE_CYCLES_P = 4
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] boot_timeout_sel,
    input wire logic timeout_action_jumper,
    input wire logic manual_reset_switch_n,
    input wire logic sys_reset_req,
    input wire logic wdt_nmi,
    input wire logic irq
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // A reset pulse from either cause stands for sixteen cycles.
    sequence rst_hold_s;
        sys_reset_req [*8] ##1 sys_reset_req [*8];
    endsequence
    sequence retrig_rd_s;
        reg_rd && clk_en && reg_addr == OFS_RETRIGGER;
    endsequence
    rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    retrig_zero_a: assert property (retrig_rd_s |=> reg_rdata == 8'h00)
        else $error("retrigger read returned data");
    nmi_pulse_a: assert property (wdt_nmi && clk_en |=> !wdt_nmi)
        else $error("nmi longer than one cycle");
    nmi_jumper_a: assert property (wdt_nmi |-> !timeout_action_jumper)
        else $error("nmi raised with reset jumper");
    reset_len_a: assert property ($rose(sys_reset_req) |-> rst_hold_s ##1 !sys_reset_req)
        else $error("reset pulse length wrong");
    sw_debounce_a: assert property (!sys_reset_req && $fell(manual_reset_switch_n)
        |=> !sys_reset_req [*3])
        else $error("switch acted before debounce");
    irq_rise_a: assert property ($rose(irq) |-> wdt_nmi || sys_reset_req || $past(reg_wr))
        else $error("irq rose without event");
    irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("irq fell without write");
endmodule
bind swt_top swt_sva #(
    .TICK_CYCLES_P(TICK_CYCLES_P),
    .DEBOUNCE_CYCLES_P(DEBOUNCE_CYCLES_P)
) swt_sva_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .boot_timeout_sel(boot_timeout_sel),
    .timeout_action_jumper(timeout_action_jumper),
    .manual_reset_switch_n(manual_reset_switch_n),
    .sys_reset_req(sys_reset_req),
    .wdt_nmi(wdt_nmi),
    .irq(irq)
);
`default_nettype wire

// >>> tb/tb_swt_top.sv
// Self-checking testbench for the system watchdog timer.
`timescale 1ns/1ns
`default_nettype none
module tb_swt_top;
    import swt_pkg::*;
    localparam int TICK = 8;
    logic core_clk = 1'h0;
    logic resetn = 1'h0;
    logic clk_en = 1'h1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic [1:0] boot_timeout_sel = 2'h0;
    logic timeout_action_jumper = 1'h0;
    logic manual_reset_switch_n = 1'h1;
    logic sys_reset_req;
    logic wdt_nmi;
    logic irq;
    logic [7:0] d;
    int n;
    int n_fail = 0;
    int check_count = 0;
    swt_top #(.TICK_CYCLES_P(TICK), .DEBOUNCE_CYCLES_P(4)) swt_top_i (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_timeout_sel(boot_timeout_sel),
        .timeout_action_jumper(timeout_action_jumper),
        .manual_reset_switch_n(manual_reset_switch_n),
        .sys_reset_req(sys_reset_req), .wdt_nmi(wdt_nmi), .irq(irq)
    );
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    // Read data stands only in the cycle after the read edge.
    task automatic rd(logic [11:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    task automatic tick(int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset();
        resetn <= 1'h0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'h1;
    endtask
    task automatic wait_fire();
        n = 0;
        while (wdt_nmi !== 1'h1 && sys_reset_req !== 1'h1 && n < 300)
        begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask
    task automatic t_regs();
        rd(OFS_PERIOD);
        chk("period_rst", d, PERIOD_RST);
        rd(OFS_INT_EN);
        chk("int_en_rst", d, 8'h00);
        wr(OFS_PERIOD, 8'hA5);
        rd(OFS_PERIOD);
        chk("period_rw", d, 8'hA5);
        rd(12'h020);
        chk("unmapped", d, 8'h00);
        wr(OFS_CTRL, 8'h02);
        rd(OFS_CTRL);
        chk("ctrl_bad", d, 8'h00);
        // The idle count holds the last loaded period, not the period register.
        rd(OFS_REMAIN);
        chk("remain_idle", d, PERIOD_RST);
    endtask
    task automatic t_boot();
        for (int i = 1; i < 4; i++)
        begin
            @(posedge core_clk);
            boot_timeout_sel <= i[1:0];
            do_reset();
            rd(OFS_REMAIN);
            chk("boot_secs", d, 8'h1E * i);
            rd(OFS_CTRL);
            chk("boot_mode", d, 8'h03);
        end
        @(posedge core_clk);
        boot_timeout_sel <= 2'h0;
        do_reset();
    endtask
    task automatic t_expire();
        wr(OFS_INT_EN, 8'h01);
        wr(OFS_PERIOD, 8'h02);
        wr(OFS_CTRL, CTRL_ENABLE);
        wait_fire();
        chk("nmi_time", n, 2 * TICK + 1);
        chk("nmi", wdt_nmi, 1'h1);
        chk("no_rst", sys_reset_req, 1'h0);
        chk("irq", irq, 1'h1);
        rd(OFS_STATUS);
        chk("status", d, 8'h01);
        rd(OFS_CTRL);
        chk("ctrl_exp", d, 8'h04);
        wr(OFS_INT_CLR, 8'h01);
        tick(1);
        chk("irq_clr", irq, 1'h0);
    endtask
    task automatic t_retrig();
        wr(OFS_PERIOD, 8'h01);
        wr(OFS_CTRL, CTRL_ENABLE);
        rd(OFS_REMAIN);
        chk("remain_load", d, 8'h01);
        // Retrigger every five cycles, well inside the eight-cycle period.
        repeat (8)
        begin
            tick(3);
            rd(OFS_RETRIGGER);
            chk("retrig_rd", d, 8'h00);
        end
        rd(OFS_CTRL);
        chk("still_run", d, 8'h01);
        wr(OFS_CTRL, CTRL_DISABLE);
        tick(30);
        rd(OFS_CTRL);
        chk("stopped", d, 8'h00);
        rd(OFS_REMAIN);
        chk("remain_hold", d, 8'h01);
    endtask
    task automatic t_jumper();
        @(posedge core_clk);
        timeout_action_jumper <= 1'h1;
        wr(OFS_PERIOD, 8'h00);
        wr(OFS_CTRL, CTRL_ENABLE);
        wait_fire();
        chk("rst_time", n, TICK + 1);
        chk("rst_out", sys_reset_req, 1'h1);
        chk("nmi_off", wdt_nmi, 1'h0);
        tick(20);
        wr(OFS_INT_CLR, 8'h03);
    endtask
    task automatic t_switch();
        @(posedge core_clk);
        manual_reset_switch_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        manual_reset_switch_n <= 1'h1;
        tick(10);
        chk("bounce", sys_reset_req, 1'h0);
        @(posedge core_clk);
        manual_reset_switch_n <= 1'h0;
        wait_fire();
        chk("debounce", n, 4);
        rd(OFS_STATUS);
        chk("sw_status", d, 8'h02);
        wr(OFS_INT_EN, 8'h03);
        tick(1);
        chk("irq_sw", irq, 1'h1);
        wr(OFS_INT_EN, 8'h01);
        tick(1);
        chk("irq_mask", irq, 1'h0);
        @(posedge core_clk);
        manual_reset_switch_n <= 1'h1;
        tick(20);
    endtask
    // A frozen clock enable must stop the count well past a full period.
    task automatic t_hold();
        wr(OFS_PERIOD, 8'h01);
        wr(OFS_CTRL, CTRL_ENABLE);
        clk_en <= 1'h0;
        repeat (20) @(posedge core_clk);
        clk_en <= 1'h1;
        rd(OFS_CTRL);
        chk("hold_run", d, 8'h01);
        chk("hold_rst", sys_reset_req, 1'h0);
        wr(OFS_CTRL, CTRL_DISABLE);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        forever #20 core_clk = ~core_clk;
    end
    initial
    begin
        #(40 * 4000);
        n_fail++;
        stop_test();
    end
    initial
    begin
        do_reset();
        t_regs();
        t_boot();
        t_expire();
        t_retrig();
        t_jumper();
        t_switch();
        t_hold();
        stop_test();
    end
endmodule
`default_nettype wire
